// >>> dssp_pkg.sv
/*
  Types shared by the dual serial port and its section engine.
  Assumes the constants header is compiled alongside.
*/
package dssp_pkg;

  // framing of one direction of one port
  typedef struct packed {
    logic fsAlt;
    logic fsLong;
    logic fsInv;
    logic fsInt;
    logic framed;
  } sect_cfg_t;

  // control register of one port, bit 0 is the lsb of wlen
  typedef struct packed {
    logic mc32;
    logic alt;
    logic en;
    logic ab;
    logic alaw;
    logic cmp;
    sect_cfg_t tx;
    sect_cfg_t rx;
    logic intClk;
    logic [3:0] wlen;
  } port_ctrl_t;

  // pin drive of one section
  typedef struct packed {
    logic fsOut;
    logic fsOe;
    logic dataOut;
    logic dataOe;
  } sect_pins_t;

  typedef enum logic [2:0] {
    SEC_IDLE = 3'b001,
    SEC_PEND = 3'b010,
    SEC_BUSY = 3'b100
  } sec_state_t;

endpackage : dssp_pkg

// >>> dual_sync_serial_port.sv
/*
  Two synchronous serial ports with register access over Avalon-MM.
  Assumes pin inputs are asynchronous to core_clk and that the bit
  clock is well below a quarter of core_clk.
*/
// Overview of operation
// - two ports, each with separate double-buffered transmit and receive
// - bit clock taken from the pin or divided internally, by config
// - receive and transmit framing are configured independently
// - frameless, or frame sync generated here or taken from outside
// - sync polarity, two widths and two timings are selectable
// - word length programmable from 3 to 16 bits
// - optional A-law or mu-law companding per port
// - receive and transmit raise their own interrupt per word
// - autobuffer moves a circular buffer, one cycle per word
// - autobuffer interrupts once the whole buffer is moved
// - first port has a 24 or 32 slot multichannel mode
// - second port pins become interrupt inputs and flags
// - internal clock stays usable in flag configuration
// - pin functions may be changed by software at any time
// - flag and interrupt functions on shared pins work together
`timescale 1ns/10ps
`default_nettype none
`include "dual_sync_serial_port_consts.svh"
module dual_sync_serial_port
  import dssp_pkg::*;
#(
  parameter int DIV_W = 16,
  parameter int AB_DEPTH = 16,
  parameter int AB_AW = 4
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic [1:0] sclkIn,
  output logic [1:0] sclkOut,
  output logic [1:0] sclkOe,
  input wire logic [1:0] rfsIn,
  output logic [1:0] rfsOut,
  output logic [1:0] rfsOe,
  input wire logic [1:0] tfsIn,
  output logic [1:0] tfsOut,
  output logic [1:0] tfsOe,
  input wire logic [1:0] drIn,
  output logic [1:0] dtOut,
  output logic [1:0] dtOe
);
  logic [7:0] meta;
  logic [7:0] syncd;
  logic [1:0] irqPrev;
  logic [`ST_W-1:0] status;
  logic [`ST_W-1:0] mask;
  logic flagOut;
  logic [`ST_W-1:0] events;
  logic [31:0] rdPort [2];

  // companding: linear 16-bit to 8-bit code
  function automatic logic [7:0] encode(input logic [15:0] x,
                                        input logic alaw);
    logic [15:0] m;
    logic [2:0] seg;
    logic [3:0] man;
    m = x[15] ? ~x : x;
    if (alaw)
      m = {4'h0, m[14:3]};
    else
    begin
      m = {3'h0, m[14:2]};
      if (m > 16'h1fde)
        m = 16'h1fde;
      m = m + 16'h0021;
    end
    seg = 3'h0;
    for (int i = 0; i < 7; i++)
      if (m >= ((alaw ? 16'h0020 : 16'h0040) << i))
        seg = 3'(i + 1);
    if (alaw)
      man = 4'(m >> ((seg == 3'h0) ? 3'h1 : seg));
    else
      man = 4'(m >> (4'(seg) + 4'h1));
    return alaw ? {~x[15], {seg, man} ^ 7'h55} : {~x[15], ~{seg, man}};
  endfunction : encode

  // companding: 8-bit code back to linear 16-bit
  function automatic logic [15:0] decode(input logic [7:0] c,
                                         input logic alaw);
    logic [7:0] v;
    logic [15:0] t;
    if (alaw)
    begin
      v = c ^ 8'h55;
      t = {8'h00, v[3:0], 4'h8};
      if (v[6:4] != 3'h0)
        t = t + 16'h0100;
      if (v[6:4] > 3'h1)
        t = t << (v[6:4] - 3'h1);
      return v[7] ? t : 16'(-t);
    end
    v = ~c;
    t = (({12'h000, v[3:0]} << 3) + 16'h0084) << v[6:4];
    t = t - 16'h0084;
    return v[7] ? 16'(-t) : t;
  endfunction : decode

  // bus decode, one wait cycle per access
  wire busReq = avs_read || avs_write;
  wire accept = busReq && !avs_waitrequest;
  wire wrEn = accept && avs_write;
  wire rdEn = accept && avs_read;
  wire isGlobal = avs_address[6];
  wire [4:0] ofs = avs_address[4:0];
  wire wrStatus = wrEn && avs_address == `OFS_STATUS;
  wire wrMask = wrEn && avs_address == `OFS_MASK;
  wire wrPins = wrEn && avs_address == `OFS_PINS;
  wire [3:0] pinsVal = {syncd[5], syncd[3], syncd[7], flagOut};
  wire [31:0] rdGlobal =
    (avs_address == `OFS_STATUS) ? {20'h0_0000, status} :
    (avs_address == `OFS_MASK) ? {20'h0_0000, mask} :
    (avs_address == `OFS_PINS) ? {28'h000_0000, pinsVal} : 32'h0000_0000;
  wire [31:0] rdMux = isGlobal ? rdGlobal : rdPort[avs_address[5]];

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end
    else if (ce)
    begin
      avs_waitrequest <= !(busReq && avs_waitrequest);
      if (avs_read && avs_waitrequest)
        avs_readdata <= rdMux;
    end
  end

  // two-flop synchronisers for every pin input
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      meta <= 8'h00;
      syncd <= 8'h00;
      irqPrev <= 2'h0;
    end
    else if (ce)
    begin
      meta <= {drIn, tfsIn, rfsIn, sclkIn};
      syncd <= meta;
      irqPrev <= {syncd[5], syncd[3]};
    end
  end

  // second port frame pins as edge interrupts
  assign events[`ST_IRQA] = syncd[3] && !irqPrev[0];
  assign events[`ST_IRQB] = syncd[5] && !irqPrev[1];

  // sticky status, write one to clear, a new event wins over the clear
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      status <= '0;
      mask <= '0;
      flagOut <= 1'b0;
      irq <= 1'b0;
    end
    else if (ce)
    begin
      status <= (status & ~(wrStatus ? avs_writedata[`ST_W-1:0] : '0))
        | events;
      if (wrMask)
        mask <= avs_writedata[`ST_W-1:0];
      if (wrPins)
        flagOut <= avs_writedata[`PIN_FLAGOUT];
      irq <= |(status & mask);
    end
  end

  for (genvar p = 0; p < 2; p++)
  begin : g_port
    port_ctrl_t ctrl;
    logic [DIV_W-1:0] div;
    logic [DIV_W-1:0] divCnt;
    logic sclkInt;
    logic bitPrev;
    logic [31:0] slots;
    logic [AB_AW-1:0] abLen;
    logic [AB_AW:0] abAddr;
    logic [AB_AW-1:0] txIdx;
    logic [AB_AW-1:0] rxIdx;
    logic [15:0] txMem [AB_DEPTH];
    logic [15:0] rxMem [AB_DEPTH];
    logic [15:0] txHold;
    logic txFull;
    logic txHoldLast;
    logic [15:0] rxHold;
    logic rxFull;
    logic [4:0] slot;
    logic inFrame;
    logic txSlotOn;
    logic rxSlotOn;
    sect_pins_t rxPins;
    sect_pins_t txPins;
    logic rxStart;
    logic txStart;
    logic rxDone;
    logic [15:0] rxRaw;

    // register access of this port
    wire sel = !isGlobal && avs_address[5] == 1'(p);
    wire wrCtrl = wrEn && sel && ofs == `OFS_CTRL;
    wire wrTx = wrEn && sel && ofs == `OFS_TX;
    wire rdRx = rdEn && sel && ofs == `OFS_RX;
    wire wrData = wrEn && sel && ofs == `OFS_ABDATA;
    wire [AB_AW-1:0] winIdx = abAddr[AB_AW-1:0];
    wire [15:0] winVal = abAddr[AB_AW] ? rxMem[winIdx] : txMem[winIdx];
    wire [3:0] stat = {rxFull, txFull, inFrame, ctrl.alt};
    assign rdPort[p] =
      (ofs == `OFS_CTRL) ? {11'h000, ctrl} :
      (ofs == `OFS_DIV) ? 32'(div) :
      (ofs == `OFS_TX) ? {12'h000, stat, txHold} :
      (ofs == `OFS_RX) ? {16'h0000, rxHold} :
      (ofs == `OFS_SLOTS) ? slots :
      (ofs == `OFS_ABLEN) ? 32'(abLen) :
      (ofs == `OFS_ABADDR) ? 32'(abAddr) :
      (ofs == `OFS_ABDATA) ? {16'h0000, winVal} : 32'h0000_0000;

    // word length clamped to at least three bits
    wire [3:0] wlenIn = avs_writedata[3:0] < `WLEN_MIN ? `WLEN_MIN
      : avs_writedata[3:0];
    // multichannel only on the first port
    wire mc = (p == 0) && ctrl.alt;
    // flag and interrupt pin use only on the second port
    wire flagMode = (p == 1) && ctrl.alt;
    wire [4:0] lastSlot = ctrl.mc32 ? `SLOTS_LAST32 : `SLOTS_LAST24;
    wire [4:0] slotNext = inFrame ? slot + 5'h1 : 5'h00;
    wire slotHit = slots[slotNext];

    // bit clock from the pin or from the divider
    wire bitClk = ctrl.intClk ? sclkInt : syncd[p];
    wire run = ctrl.en && !flagMode;
    wire bitRise = run && bitClk && !bitPrev;
    wire bitFall = run && !bitClk && bitPrev;
    wire divWrap = divCnt >= div;

    // divider keeps running in flag configuration
    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
      begin
        divCnt <= '0;
        sclkInt <= 1'b0;
        bitPrev <= 1'b0;
      end
      else if (ce)
      begin
        divCnt <= divWrap ? '0 : divCnt + 1'b1;
        if (divWrap)
          sclkInt <= !sclkInt;
        bitPrev <= bitClk;
      end
    end

    // each fed its own framing configuration
    serial_section #(.IS_TX(1'b0)) u_rx (
      .core_clk(core_clk), .rst(rst), .ce(ce),
      .bitRise(bitRise), .bitFall(bitFall), .cfg(ctrl.rx),
      .wlen(ctrl.wlen), .ready(1'b1), .freeRun(mc && inFrame),
      .useExt(1'b0), .extTrig(1'b0), .fsPin(syncd[2 + p]),
      .dataPin(syncd[6 + p]), .txWord(16'h0000), .pins(rxPins),
      .started(rxStart), .done(rxDone), .rxWord(rxRaw)
    );

    // transmit word companded on its way into the shifter
    serial_section #(.IS_TX(1'b1)) u_tx (
      .core_clk(core_clk), .rst(rst), .ce(ce),
      .bitRise(bitRise), .bitFall(bitFall), .cfg(ctrl.tx),
      .wlen(ctrl.wlen), .ready(txFull), .freeRun(1'b0),
      .useExt(mc), .extTrig(rxStart), .fsPin(syncd[4 + p]),
      .dataPin(1'b0),
      .txWord(ctrl.cmp ? {8'h00, encode(txHold, ctrl.alaw)} : txHold),
      .pins(txPins), .started(txStart), .done(), .rxWord()
    );

    wire txTake = txStart && txFull && (!mc || slotHit);
    wire rxStore = rxDone && (!mc || rxSlotOn);
    wire [15:0] rxWord = ctrl.cmp ? decode(rxRaw[7:0], ctrl.alaw) : rxRaw;
    wire abFill = ctrl.ab && ctrl.en && !txFull && !txTake;

    assign events[p * 4 + `ST_RXWORD] = rxStore && !ctrl.ab;
    assign events[p * 4 + `ST_TXWORD] = txTake && !ctrl.ab;
    // buffer events when the last entry has moved
    assign events[p * 4 + `ST_RXBUF] = rxStore && ctrl.ab && rxIdx == abLen;
    assign events[p * 4 + `ST_TXBUF] = txTake && ctrl.ab && txHoldLast;
    assign events[`ST_OVR + p] = rxStore && !ctrl.ab && rxFull;

    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
      begin
        ctrl <= `CTRL_RST;
        div <= DIV_W'(`DIV_RST);
        slots <= 32'h0000_0000;
        abLen <= '0;
        abAddr <= '0;
      end
      else if (ce)
      begin
        if (wrCtrl)
          ctrl <= {avs_writedata[20:4], wlenIn};
        if (wrEn && sel && ofs == `OFS_DIV)
          div <= avs_writedata[DIV_W-1:0];
        if (wrEn && sel && ofs == `OFS_SLOTS)
          slots <= avs_writedata;
        if (wrEn && sel && ofs == `OFS_ABLEN)
          abLen <= avs_writedata[AB_AW-1:0];
        if (wrEn && sel && ofs == `OFS_ABADDR)
          abAddr <= avs_writedata[AB_AW:0];
      end
    end

    // holding registers ahead of and behind the shifters
    // autobuffer refills the holding register in one cycle
    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
      begin
        txHold <= 16'h0000;
        txFull <= 1'b0;
        txHoldLast <= 1'b0;
        txIdx <= '0;
        rxHold <= 16'h0000;
        rxFull <= 1'b0;
        rxIdx <= '0;
      end
      else if (ce)
      begin
        // a write in the take cycle refills the holding register
        if (wrTx && !ctrl.ab)
        begin
          txHold <= avs_writedata[15:0];
          txFull <= 1'b1;
          txHoldLast <= 1'b0;
        end
        else if (txTake)
          txFull <= 1'b0;
        else if (abFill)
        begin
          txHold <= txMem[txIdx];
          txFull <= 1'b1;
          txHoldLast <= txIdx == abLen;
          txIdx <= (txIdx == abLen) ? '0 : txIdx + 1'b1;
        end
        if (wrCtrl)
        begin
          txIdx <= '0;
          rxIdx <= '0;
        end
        if (rxStore && ctrl.ab)
          rxIdx <= (rxIdx == abLen) ? '0 : rxIdx + 1'b1;
        if (rxStore && !ctrl.ab)
        begin
          rxHold <= rxWord;
          rxFull <= 1'b1;
        end
        else if (rdRx)
          rxFull <= 1'b0;
      end
    end

    // buffer memories, hardware store has priority over the window
    always_ff @(posedge core_clk)
    begin
      if (ce && wrData && !abAddr[AB_AW])
        txMem[winIdx] <= avs_writedata[15:0];
      if (ce && rxStore && ctrl.ab)
        rxMem[rxIdx] <= rxWord;
      else if (ce && wrData && abAddr[AB_AW])
        rxMem[winIdx] <= avs_writedata[15:0];
    end

    // slot count, frame restarts after the last slot
    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
      begin
        slot <= 5'h00;
        inFrame <= 1'b0;
        txSlotOn <= 1'b1;
        rxSlotOn <= 1'b1;
      end
      else if (ce)
      begin
        if (rxStart)
        begin
          slot <= slotNext;
          inFrame <= mc && slotNext != lastSlot;
          rxSlotOn <= !mc || slotHit;
          txSlotOn <= !mc || (slotHit && txFull);
        end
        else if (!mc)
          inFrame <= 1'b0;
      end
    end

    // sync pins driven only when generated here
    // polarity and width come from the section
    // second port's data pin becomes a flag in the alternate mode
    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
      begin
        sclkOut[p] <= 1'b0;
        sclkOe[p] <= 1'b0;
        rfsOut[p] <= 1'b0;
        rfsOe[p] <= 1'b0;
        tfsOut[p] <= 1'b0;
        tfsOe[p] <= 1'b0;
        dtOut[p] <= 1'b0;
        dtOe[p] <= 1'b0;
      end
      else if (ce)
      begin
        sclkOut[p] <= sclkInt;
        sclkOe[p] <= ctrl.intClk;
        rfsOut[p] <= rxPins.fsOut;
        rfsOe[p] <= rxPins.fsOe && run;
        tfsOut[p] <= txPins.fsOut;
        tfsOe[p] <= txPins.fsOe && run;
        dtOut[p] <= flagMode ? flagOut : txPins.dataOut;
        dtOe[p] <= flagMode || (txPins.dataOe && txSlotOn && run);
      end
    end
  end
endmodule : dual_sync_serial_port
`default_nettype wire

// >>> dual_sync_serial_port_consts.svh
/*
  Offsets, field positions and reset values of the dual serial port.
  Assumes byte addressing on a 32-bit Avalon-MM register bus.
*/
`ifndef DUAL_SYNC_SERIAL_PORT_CONSTS_SVH
`define DUAL_SYNC_SERIAL_PORT_CONSTS_SVH

// per-port window, port select is address bit 5
`define OFS_CTRL 5'h00
`define OFS_DIV 5'h04
`define OFS_TX 5'h08
`define OFS_RX 5'h0c
`define OFS_SLOTS 5'h10
`define OFS_ABLEN 5'h14
`define OFS_ABADDR 5'h18
`define OFS_ABDATA 5'h1c
// global registers, selected by address bit 6
`define OFS_STATUS 7'h40
`define OFS_MASK 7'h44
`define OFS_PINS 7'h48

// status bit positions, per port nibble plus shared bits
`define ST_RXWORD 0
`define ST_TXWORD 1
`define ST_RXBUF 2
`define ST_TXBUF 3
`define ST_IRQA 8
`define ST_IRQB 9
`define ST_OVR 10
`define ST_W 12
// pins register bit positions
`define PIN_FLAGOUT 0
`define PIN_FLAGIN 1
`define PIN_IRQA 2
`define PIN_IRQB 3

// reset values, minimum word length code and last slot numbers
`define CTRL_RST 21'h0_000f
`define DIV_RST 16'h0004
`define WLEN_MIN 4'h2
`define SLOTS_LAST24 5'h17
`define SLOTS_LAST32 5'h1f

`endif

// >>> dual_sync_serial_port_sva.sv
/* checker: bus handshake, reset state, data timing, irq release.
   assumes it is bound to the dual serial port top. */
`timescale 1ns/10ps
`default_nettype none
module dual_sync_serial_port_sva (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic irq,
  input wire logic [1:0] sclkOut,
  input wire logic [1:0] sclkOe,
  input wire logic [1:0] dtOut,
  input wire logic [1:0] dtOe,
  input wire logic [1:0] tfsOe
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  logic wrAcc;
  // accepted write
  assign wrAcc = avs_write && !avs_waitrequest;
  // request still waiting, and the answer cycle
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest && ce;
  endsequence
  sequence s_acc;
    !avs_waitrequest && ce;
  endsequence
  property p_waitAns;
    s_req |=> !avs_waitrequest;
  endproperty
  a_waitAns: assert property (p_waitAns) else $error("no answer");
  property p_waitOne;
    s_acc |=> avs_waitrequest;
  endproperty
  a_waitOne: assert property (p_waitOne) else $error("long answer");
  property p_waitIdle;
    !(avs_read || avs_write) && ce |=> avs_waitrequest;
  endproperty
  a_waitIdle: assert property (p_waitIdle) else $error("stray ack");
  property p_rdZero;
    s_req ##0 (avs_read && avs_address inside {[7'h4c:7'h5f]})
      |=> avs_readdata == 32'h0000_0000;
  endproperty
  a_rdZero: assert property (p_rdZero) else $error("hole not 0");
  property p_rdHold;
    !avs_read |=> $stable(avs_readdata);
  endproperty
  a_rdHold: assert property (p_rdHold) else $error("rdata moved");
  property p_rstOut;
    $fell(rst) |-> avs_waitrequest && !irq && dtOe == 2'b00
      && tfsOe == 2'b00;
  endproperty
  a_rstOut: assert property (p_rstOut) else $error("reset state");
  property p_dtEdge;
    sclkOe[0] && dtOe[0] && $past(dtOe[0]) && $changed(dtOut[0])
      |-> $past(sclkOut[0]) || $past(sclkOut[0], 2)
      || $past(sclkOut[0], 3);
  endproperty
  a_dtEdge: assert property (p_dtEdge) else $error("data edge");
  property p_irqFall;
    $fell(irq) |-> $past(wrAcc) || $past(wrAcc, 2);
  endproperty
  a_irqFall: assert property (p_irqFall) else $error("irq fell");
endmodule : dual_sync_serial_port_sva
bind dual_sync_serial_port dual_sync_serial_port_sva u_sva (.core_clk,
  .rst, .ce, .avs_address, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .irq, .sclkOut, .sclkOe, .dtOut, .dtOe, .tfsOe);
`default_nettype wire

// >>> dual_sync_serial_port_tb.sv
/* bench for the dual serial port: registers, loopback, codec, flags.
   assumes the codec model and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module dual_sync_serial_port_tb;
  logic core_clk = 0, rst = 1, ce = 1, rd = 0, wr = 0;
  logic [6:0] addr = '0;
  logic [31:0] wdata = '0, rdata, q;
  logic waitReq, irq, cClk, cFs, cData;
  logic [1:0] sclkOut, sclkOe, tfsOut, tfsOe, dtOut, dtOe;
  int errTotal = 0, checked = 0, cyc = 0;
  dual_sync_serial_port dut (.core_clk, .rst, .ce, .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
    .avs_readdata(rdata), .avs_waitrequest(waitReq), .irq,
    .sclkIn({cClk, sclkOut[0]}), .sclkOut, .sclkOe,
    .rfsIn({cFs, tfsOut[0]}), .rfsOut(), .rfsOe(), .tfsIn(2'b00),
    .tfsOut, .tfsOe, .drIn({cData, dtOut[0]}), .dtOut, .dtOe);
  serial_codec_model codec (.txClk(sclkOut[0]), .txFs(tfsOut[0]),
    .txData(dtOut[0]), .sclk(cClk), .fs(cFs), .data(cData));
  // clock and hang limit
  initial
  begin
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errTotal++;
      finishTest();
    end
  end
  task automatic chk(input logic [31:0] seen, exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [6:0] a,
    input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    // hold the request until waitrequest is seen low
    do
      @(posedge core_clk);
    while (waitReq !== 1'b0);
    q = rdata;
    rd <= 0;
    wr <= 0;
  endtask : bus
  task automatic rdc(input logic [6:0] a, input logic [31:0] e,
    input string what);
    bus(0, a, 32'h0000_0000);
    chk(q, e, what);
  endtask : rdc
  task automatic testRegs();
    rdc(7'h00, 32'h0000_000f, "ctrl0");
    rdc(7'h24, 32'h0000_0004, "div1");
    bus(1, 7'h4c, 32'hffff_ffff);
    rdc(7'h4c, 32'h0000_0000, "hole");
    bus(1, 7'h04, 32'h0000_0007);
    rdc(7'h04, 32'h0000_0007, "div0");
    $display("regs done");
  endtask : testRegs
  task automatic waitWords(input int n);
    for (int i = 0; i < 3000 && codec.words < n; i++)
      @(posedge core_clk);
  endtask : waitWords
  task automatic testLoop();
    bus(1, 7'h00, 32'h0004_0c37);
    bus(1, 7'h08, 32'h0000_00a5);
    // next word goes in only once the first has been taken
    do
      bus(0, 7'h08, 32'h0000_0000);
    while (q[18]);
    bus(1, 7'h08, 32'h0000_003c);
    waitWords(1);
    chk(codec.rxWord, 32'h0000_00a5, "word1");
    waitWords(2);
    chk(codec.rxWord, 32'h0000_003c, "word2");
    repeat (20) @(posedge core_clk);
    rdc(7'h0c, 32'h0000_003c, "rx0");
    rdc(7'h40, 32'h0000_0403, "stat0");
    chk(irq, 1'b0, "masked");
    bus(1, 7'h44, 32'h0000_0002);
    repeat (3) @(posedge core_clk);
    chk(irq, 1'b1, "irq");
    bus(1, 7'h40, 32'hffff_ffff);
    repeat (3) @(posedge core_clk);
    chk(irq, 1'b0, "irq clr");
    // mu-law: full scale goes out as code 80 and comes back expanded
    bus(1, 7'h00, 32'h0004_8c37);
    bus(1, 7'h08, 32'h0000_7fff);
    waitWords(3);
    chk(codec.rxWord, 32'h0000_0080, "mu code");
    repeat (20) @(posedge core_clk);
    rdc(7'h0c, 32'h0000_7d7c, "mu lin");
    bus(1, 7'h40, 32'hffff_ffff);
    $display("loop done");
  endtask : testLoop
  task automatic testExt();
    bus(1, 7'h20, 32'h0004_002f);
    codec.sendWord(16'h1234);
    repeat (8) @(posedge core_clk);
    rdc(7'h40, 32'h0000_0110, "stat1");
    rdc(7'h2c, 32'h0000_1234, "rx1");
    bus(1, 7'h40, 32'hffff_ffff);
    $display("ext done");
  endtask : testExt
  task automatic testFlag();
    bus(1, 7'h20, 32'h000c_001f);
    bus(1, 7'h48, 32'h0000_0001);
    codec.pinLevels(1, 1);
    repeat (8) @(posedge core_clk);
    chk({dtOe[1], dtOut[1]}, 2'b11, "flag out");
    chk(sclkOe[1], 1'b1, "sclk oe");
    rdc(7'h48, 32'h0000_0007, "pins");
    rdc(7'h40, 32'h0000_0100, "irqA");
    codec.pinLevels(0, 0);
    bus(1, 7'h20, 32'h0004_002f);
    repeat (4) @(posedge core_clk);
    chk(dtOe[1], 1'b0, "dt off");
    $display("flag done");
  endtask : testFlag
  task automatic finishTest();
    $display("checks %0d errors %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finishTest
  // main sequence
  initial
  begin
    repeat (20) @(posedge core_clk);
    rst <= 0;
    testRegs();
    testLoop();
    testExt();
    testFlag();
    finishTest();
  end
endmodule : dual_sync_serial_port_tb
`default_nettype wire

// >>> serial_codec_model.sv
/* codec model: hears the first port's transmitter and drives the
   second port's receive pins. assumes 8-bit words from the port. */
`timescale 1ns/10ps
`default_nettype none
module serial_codec_model (
  input wire logic txClk,
  input wire logic txFs,
  input wire logic txData,
  output logic sclk,
  output logic fs,
  output logic data
);
  logic [15:0] sh = '0;
  logic [15:0] rxWord = '0;
  int left = 0;
  int words = 0;
  // pins at rest
  initial
  begin
    sclk = 0;
    fs = 0;
    data = 0;
  end
  always @(negedge txClk)
  begin
    if (left > 0)
    begin
      sh = {sh[14:0], txData};
      left--;
      if (left == 0)
      begin
        rxWord = {8'h00, sh[7:0]};
        words++;
      end
    end
    else if (txFs)
      left = 8;
  end
  task automatic sendWord(input logic [15:0] w);
    for (int i = 0; i < 17; i++)
    begin
      sclk = 1;
      fs = (i == 0);
      if (i > 0)
        data = w[16 - i];
      #200;
      sclk = 0;
      #200;
    end
    data = ~data; // line flipped once the last bit has been clocked
  endtask : sendWord
  task automatic pinLevels(input logic f, input logic d);
    fs = f;
    data = d;
  endtask : pinLevels
endmodule : serial_codec_model
`default_nettype wire

// >>> serial_section.sv
/*
  One transmit or receive section: frame sync detect or generate,
  bit counter and shifter. Assumes bitRise and bitFall are one-cycle
  pulses of the bit clock and that pin inputs are already synchronised.
*/
`timescale 1ns/10ps
`default_nettype none
module serial_section
  import dssp_pkg::*;
#(
  parameter bit IS_TX = 1'b0
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic bitRise,
  input wire logic bitFall,
  input wire sect_cfg_t cfg,
  input wire logic [3:0] wlen,
  input wire logic ready,
  input wire logic freeRun,
  input wire logic useExt,
  input wire logic extTrig,
  input wire logic fsPin,
  input wire logic dataPin,
  input wire logic [15:0] txWord,
  output sect_pins_t pins,
  output logic started,
  output logic done,
  output logic [15:0] rxWord
);
  sec_state_t state;
  logic fsPrev;
  logic [3:0] cnt;
  logic [15:0] shreg;

  // trigger selection for the start of a word
  wire fsHit = fsPin ^ cfg.fsInv;
  wire busy = (state == SEC_BUSY);
  wire atEnd = !busy || (IS_TX && cnt == 4'h0);
  wire extFs = cfg.fsAlt ? fsHit : fsPrev;
  wire intFs = cfg.fsAlt ? ready : (state == SEC_PEND);
  wire selfFs = cfg.fsInt ? intFs : extFs;
  wire freeTrig = !cfg.framed || freeRun;
  wire trig = useExt ? extTrig : (freeTrig ? ready : selfFs);
  wire startNow = bitRise && atEnd && trig;
  wire armOk = cfg.framed && cfg.fsInt && !cfg.fsAlt && !freeRun;
  wire armNow = bitRise && atEnd && !startNow && armOk && !useExt
    && ready && state != SEC_PEND;
  wire endEdge = IS_TX ? bitRise : bitFall;
  wire endNow = endEdge && busy && cnt == 4'h0;
  wire shiftNow = endEdge && busy && cnt != 4'h0;
  wire fsLvl = (startNow && cfg.fsAlt) || armNow
    || (cfg.fsLong && (startNow || (busy && !endNow)));

  assign started = startNow;

  // word state and bit count
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= SEC_IDLE;
      cnt <= 4'h0;
      done <= 1'b0;
    end
    else if (ce)
    begin
      done <= endNow;
      if (startNow)
      begin
        state <= SEC_BUSY;
        cnt <= wlen;
      end
      else if (armNow)
        state <= SEC_PEND;
      else if (endNow)
        state <= SEC_IDLE;
      else if (shiftNow)
        cnt <= cnt - 4'h1;
    end
  end

  // shifter, msb first, transmit drives on rise, receive samples on fall
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      shreg <= 16'h0000;
      rxWord <= 16'h0000;
      pins.dataOut <= 1'b0;
      pins.dataOe <= 1'b0;
    end
    else if (ce)
    begin
      if (IS_TX && startNow)
      begin
        shreg <= txWord;
        pins.dataOut <= txWord[wlen];
        pins.dataOe <= 1'b1;
      end
      else if (IS_TX && shiftNow)
        pins.dataOut <= shreg[cnt - 4'h1];
      else if (IS_TX && endNow)
        pins.dataOe <= 1'b0;
      else if (!IS_TX && startNow)
        shreg <= 16'h0000;
      else if (!IS_TX && bitFall && busy)
        shreg <= {shreg[14:0], dataPin};
      if (!IS_TX && endNow)
        rxWord <= {shreg[14:0], dataPin};
    end
  end

  // frame sync history and generated pulse
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      fsPrev <= 1'b0;
      pins.fsOut <= 1'b0;
      pins.fsOe <= 1'b0;
    end
    else if (ce)
    begin
      pins.fsOe <= cfg.framed && cfg.fsInt && !useExt;
      // sync taken on the fall, so one launched on a rise is seen in time
      if (bitFall)
        fsPrev <= fsHit;
      if (bitRise)
        pins.fsOut <= fsLvl ^ cfg.fsInv;
    end
  end
endmodule : serial_section
`default_nettype wire
